// ==== hw/key_irq_params.svh ====
`ifndef KEY_IRQ_PARAMS_SVH
`define KEY_IRQ_PARAMS_SVH

// register indexes; byte address is four times the index
`define IDX_CTRL 16'h0000
`define IDX_WIDE_SP 16'h0001
`define IDX_NIB_SP 16'h0002
`define IDX_CMD 16'h0003
`define IDX_STATUS 16'h0004
`define IDX_FILTER 16'h0005
`define IDX_SELECT 16'hFF54
`define IDX_MASK 16'hFFEB
`define IDX_FLAG 16'hFFFB

// widths
`define NUM_KEYS 4
`define WIDE_SP_W 10
`define NIB_SP_W 8

// field positions
`define CTRL_GE_BIT 0
`define CMD_SLEEP_BIT 0
`define CMD_RETURN_FROM_HANDLER_OP_BIT 1
`define ST_SP_OK_BIT 0
`define ST_SLEEP_BIT 1
`define ST_IRQ_BIT 2
`define ST_LEVEL_LSB 4
`define TIMER_LINE 3

// reset values
`define RST_KEYS 4'h0
`define RST_FILTER 8'h00
`define RST_WIDE_SP 10'h000
`define RST_NIB_SP 8'h00

// filter stability counts in clock cycles
`define FILT_LIMIT_SHORT 7'h04
`define FILT_LIMIT_MID 7'h10
`define FILT_LIMIT_LONG 7'h40

`endif

// ==== hw/key_irq_pkg.sv ====
package key_irq_pkg;

    typedef enum logic [0:0] {
        PWR_RUN = 1'b0,
        PWR_SLEEP = 1'b1
    } power_state_e;

    typedef enum logic [1:0] {
        FILT_BYPASS = 2'b00,
        FILT_SHORT = 2'b01,
        FILT_MID = 2'b10,
        FILT_LONG = 2'b11
    } filter_code_e;

    typedef logic [3:0] key_vec_t;

endpackage : key_irq_pkg

// ==== hw/key_line_filter.sv ====
`timescale 1ns/10ps
`include "key_irq_params.svh"

module key_line_filter
    import key_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin side
    input wire logic line_pin,
    input wire filter_code_e filt_code,
    input wire logic run,
    // filtered result
    output logic level,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic filt_r;
    logic prev_r;
    logic [6:0] cnt_r;
    logic [6:0] limit;

    always_comb begin
        case (filt_code)
            FILT_SHORT: limit = `FILT_LIMIT_SHORT;
            FILT_MID: limit = `FILT_LIMIT_MID;
            FILT_LONG: limit = `FILT_LIMIT_LONG;
            default: limit = 7'h01;
        endcase
    end

    // lines idle high behind pull-ups
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= line_pin;
            sync_r <= meta_r;
        end
    end

    // filter freezes while the peripheral clock is withheld, except bypass, which keeps following the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_r <= 1'b1;
            cnt_r <= 7'h00;
        end else if (filt_code == FILT_BYPASS) begin
            filt_r <= sync_r;
            cnt_r <= 7'h00;
        end else if (run) begin
            if (sync_r == filt_r) begin
                cnt_r <= 7'h00;
            end else if (cnt_r == limit - 7'h01) begin
                filt_r <= sync_r;
                cnt_r <= 7'h00;
            end else begin
                cnt_r <= cnt_r + 7'h01;
            end
        end
    end

    assign level = (filt_code == FILT_BYPASS) ? sync_r : filt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= level;
        end
    end

    // a key press pulls the line low
    assign fall = prev_r & ~level;

endmodule : key_line_filter

// ==== hw/key_irq_sleep_ctrl.sv ====
`timescale 1ns/10ps
`include "key_irq_params.svh"

// How it works
// - flags set even when mask bit is 0
// - flag holds until written one; re-raises
// - no interrupt, NMI too, before both pointers
// - rewriting one pointer blocks until other written
// - only a key flag event ends sleep
// - four lines, independent flag, select, mask
// - fast oscillator enable held 0 in every state; sleep withholds peripheral clock
// - fourth key line doubles as timer clock
// - select bits together at index FF54
// - mask bits together at index FFEB
// - flag bits together at index FFFB
module key_irq_sleep_ctrl
    import key_irq_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // key input pins
    input wire logic [3:0] KEY_IN,
    // cpu core
    input wire logic IRQ_ACK,
    input wire logic NMI_REQ,
    output logic IRQ,
    output logic NMI_OUT,
    // clock control
    output logic FAST_OSC_EN,
    output logic SLOW_OSC_RUN,
    output logic PERIPH_CLK_EN,
    output logic TIMER_EXT_CLK
);
    logic rst_meta_r;
    logic rst_n_r;
    logic wr_pend_r;
    logic [31:0] addr_r;
    logic ge_r;
    logic [`WIDE_SP_W-1:0] wide_sp_r;
    logic [`NIB_SP_W-1:0] nib_sp_r;
    logic wide_set_r;
    logic nib_set_r;
    logic sp_ok;
    key_vec_t port_irq_select_r;
    key_vec_t port_irq_mask_r;
    key_vec_t port_irq_flag_r;
    key_vec_t port_irq_flag_nxt;
    key_vec_t flag_clr;
    key_vec_t flag_set;
    logic [7:0] port_filter_select_r;
    power_state_e pwr_r;
    power_state_e pwr_nxt;
    key_vec_t key_level;
    key_vec_t key_fall;
    logic irq_nxt;
    logic wr_wide;
    logic wr_nib;
    logic wr_cmd;
    logic addr_phase;

    function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
        hit = (a == {14'h0000, idx, 2'b00});
    endfunction : hit

    // reset release through two flops
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_KEYS; g++) begin : g_line
            key_line_filter u_filt (
                .clk(REF_CLK),
                .rst_n(rst_n_r),
                .line_pin(KEY_IN[g]),
                .filt_code(filter_code_e'(port_filter_select_r[2*g +: 2])),
                .run(pwr_r == PWR_RUN),
                .level(key_level[g]),
                .fall(key_fall[g])
            );
        end
    endgenerate

    // ahb address phase; zero wait, always okay
    assign addr_phase = HSEL && HTRANS[1] && HREADY;

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wr_pend_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
        end else begin
            wr_pend_r <= addr_phase && HWRITE;
            if (addr_phase) begin
                addr_r <= HADDR;
            end
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    assign wr_wide = wr_pend_r && hit(addr_r, `IDX_WIDE_SP);
    assign wr_nib = wr_pend_r && hit(addr_r, `IDX_NIB_SP);
    assign wr_cmd = wr_pend_r && hit(addr_r, `IDX_CMD);

    // read data latched at the address phase; unmapped reads zero
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE) begin
            HRDATA <= 32'h0000_0000;
            if (hit(HADDR, `IDX_CTRL)) begin
                HRDATA[`CTRL_GE_BIT] <= ge_r;
            end
            if (hit(HADDR, `IDX_WIDE_SP)) begin
                HRDATA[`WIDE_SP_W-1:0] <= wide_sp_r;
            end
            if (hit(HADDR, `IDX_NIB_SP)) begin
                HRDATA[`NIB_SP_W-1:0] <= nib_sp_r;
            end
            if (hit(HADDR, `IDX_STATUS)) begin
                HRDATA[`ST_SP_OK_BIT] <= sp_ok;
                HRDATA[`ST_SLEEP_BIT] <= (pwr_r == PWR_SLEEP);
                HRDATA[`ST_IRQ_BIT] <= IRQ;
                HRDATA[`ST_LEVEL_LSB +: 4] <= key_level;
            end
            if (hit(HADDR, `IDX_FILTER)) begin
                HRDATA[7:0] <= port_filter_select_r;
            end
            if (hit(HADDR, `IDX_SELECT)) begin
                HRDATA[3:0] <= port_irq_select_r;
            end
            if (hit(HADDR, `IDX_MASK)) begin
                HRDATA[3:0] <= port_irq_mask_r;
            end
            if (hit(HADDR, `IDX_FLAG)) begin
                HRDATA[3:0] <= port_irq_flag_r;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            port_irq_select_r <= `RST_KEYS;
            port_irq_mask_r <= `RST_KEYS;
            port_filter_select_r <= `RST_FILTER;
        end else if (wr_pend_r) begin
            if (hit(addr_r, `IDX_SELECT)) begin
                port_irq_select_r <= HWDATA[3:0];
            end
            if (hit(addr_r, `IDX_MASK)) begin
                port_irq_mask_r <= HWDATA[3:0];
            end
            if (hit(addr_r, `IDX_FILTER)) begin
                port_filter_select_r <= HWDATA[7:0];
            end
        end
    end

    // set ignores the mask; one flag per line
    assign flag_set = key_fall & port_irq_select_r;
    assign flag_clr = (wr_pend_r && hit(addr_r, `IDX_FLAG)) ?
                      HWDATA[3:0] : `RST_KEYS;
    // write one clears; a new event wins
    assign port_irq_flag_nxt = (port_irq_flag_r & ~flag_clr) | flag_set;

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            port_irq_flag_r <= `RST_KEYS;
        end else begin
            port_irq_flag_r <= port_irq_flag_nxt;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wide_sp_r <= `RST_WIDE_SP;
            nib_sp_r <= `RST_NIB_SP;
            wide_set_r <= 1'b0;
            nib_set_r <= 1'b0;
        end else begin
            if (wr_wide) begin
                wide_sp_r <= HWDATA[`WIDE_SP_W-1:0];
                wide_set_r <= 1'b1;
                if (sp_ok) begin
                    nib_set_r <= 1'b0;
                end
            end
            if (wr_nib) begin
                nib_sp_r <= HWDATA[`NIB_SP_W-1:0];
                nib_set_r <= 1'b1;
                if (sp_ok) begin
                    wide_set_r <= 1'b0;
                end
            end
        end
    end

    assign sp_ok = wide_set_r && nib_set_r;

    // taking an interrupt clears enable; the return op restores it
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ge_r <= 1'b0;
        end else if (wr_pend_r && hit(addr_r, `IDX_CTRL)) begin
            ge_r <= HWDATA[`CTRL_GE_BIT];
        end else if (wr_cmd && HWDATA[`CMD_RETURN_FROM_HANDLER_OP_BIT]) begin
            ge_r <= 1'b1;
        end else if (IRQ_ACK) begin
            ge_r <= 1'b0;
        end
    end

    // only a key flag event wakes; relies on bypass filter
    always_comb begin
        case (pwr_r)
            PWR_RUN: begin
                pwr_nxt = (wr_cmd && HWDATA[`CMD_SLEEP_BIT]) ?
                          PWR_SLEEP : PWR_RUN;
            end
            PWR_SLEEP: begin
                pwr_nxt = (|flag_set) ? PWR_RUN : PWR_SLEEP;
            end
            default: begin
                pwr_nxt = PWR_RUN;
            end
        endcase
    end

    // peripheral clock follows the power state; fast oscillator enable stays 0 from reset
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pwr_r <= PWR_RUN;
            FAST_OSC_EN <= 1'b0;
            PERIPH_CLK_EN <= 1'b1;
            SLOW_OSC_RUN <= 1'b1;
        end else begin
            pwr_r <= pwr_nxt;
            if (pwr_nxt == PWR_SLEEP) begin
                FAST_OSC_EN <= 1'b0;
            end else if (wr_cmd) begin
                FAST_OSC_EN <= FAST_OSC_EN;
            end
            PERIPH_CLK_EN <= (pwr_nxt == PWR_RUN);
            SLOW_OSC_RUN <= 1'b1;
        end
    end

    assign irq_nxt = |(port_irq_flag_r & port_irq_mask_r) && ge_r && sp_ok;

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            IRQ <= 1'b0;
            NMI_OUT <= 1'b0;
            TIMER_EXT_CLK <= 1'b1;
        end else begin
            IRQ <= irq_nxt;
            NMI_OUT <= NMI_REQ && sp_ok;
            // line still feeds its own flag logic
            TIMER_EXT_CLK <= key_level[`TIMER_LINE];
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!rst_n_r);

    property p_set_unmasked;
        (flag_set[0] && !port_irq_mask_r[0]) |=> port_irq_flag_r[0];
    endproperty
    a_set_unmasked: assert property (p_set_unmasked)
        else $error("flag not set while masked");

    property p_flag_holds;
        (port_irq_flag_r[1] && !flag_clr[1]) |=> port_irq_flag_r[1];
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag dropped without write one");

    // a return op with a pending unmasked flag must raise the request again
    property p_reraise;
        (wr_cmd && HWDATA[`CMD_RETURN_FROM_HANDLER_OP_BIT] && sp_ok
         && |(port_irq_flag_r & port_irq_mask_r)) |=> ##1 IRQ;
    endproperty
    a_reraise: assert property (p_reraise)
        else $error("pending interrupt not raised");

    property p_block_pair;
        !sp_ok |=> (!IRQ && !NMI_OUT);
    endproperty
    a_block_pair: assert property (p_block_pair)
        else $error("interrupt passed before pointer pair");

    property p_rewrite_one;
        (sp_ok && wr_wide && !wr_nib) |=> !sp_ok ##1 !IRQ;
    endproperty
    a_rewrite_one: assert property (p_rewrite_one)
        else $error("pointer pair not reopened");

    property p_only_key_wakes;
        (pwr_r == PWR_SLEEP && !(|flag_set)) |=> (pwr_r == PWR_SLEEP);
    endproperty
    a_only_key_wakes: assert property (p_only_key_wakes)
        else $error("sleep left without key event");

    property p_line_own;
        (!port_irq_flag_r[2] && !flag_set[2]) |=> !port_irq_flag_r[2];
    endproperty
    a_line_own: assert property (p_line_own)
        else $error("flag set by another line");

    property p_sleep_clocks;
        (pwr_r == PWR_SLEEP) |-> (!FAST_OSC_EN && !PERIPH_CLK_EN
                                  && SLOW_OSC_RUN);
    endproperty
    a_sleep_clocks: assert property (p_sleep_clocks)
        else $error("clocks running in sleep");

    property p_timer_line;
        1'b1 |=> (TIMER_EXT_CLK == $past(key_level[`TIMER_LINE]));
    endproperty
    a_timer_line: assert property (p_timer_line)
        else $error("timer clock does not follow line");

    property p_irq_cause;
        IRQ |-> $past(irq_nxt);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("request without cause");

    c_wake: cover property ((pwr_r == PWR_SLEEP) ##1 (pwr_r == PWR_RUN));
    c_irq: cover property ($rose(IRQ));
    c_pair: cover property ($rose(sp_ok));
    c_nmi: cover property ($rose(NMI_OUT));

endmodule : key_irq_sleep_ctrl

// ==== sim/cpu_core_model.sv ====
`timescale 1ns/10ps

// stands in for the cpu core: takes a pending request after a set delay
module cpu_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    input wire logic irq,
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    output logic irq_ack
);
    logic [3:0] wait_r;
    logic taken_r;

    // take once
    // one ack per request; irq lingers two cycles after the ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 4'h0;
            taken_r <= 1'b0;
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            if (!irq) begin
                taken_r <= 1'b0;
            end
            if (irq && ack_en && !taken_r) begin
                if (wait_r == ack_delay) begin
                    irq_ack <= 1'b1;
                    taken_r <= 1'b1;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else begin
                wait_r <= 4'h0;
            end
        end
    end
endmodule : cpu_core_model

// ==== sim/key_irq_sleep_ctrl_tb.sv ====
`timescale 1ns/10ps
`include "key_irq_params.svh"

module key_irq_sleep_ctrl_tb import key_irq_pkg::*;;
    logic REF_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0000_0000;
    logic [1:0] HTRANS = 2'b00;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, IRQ, IRQ_ACK, NMI_OUT;
    logic FAST_OSC_EN, SLOW_OSC_RUN, PERIPH_CLK_EN, TIMER_EXT_CLK;
    logic [3:0] KEY_IN = 4'hf;
    logic NMI_REQ = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_delay = 4'h1;
    logic [31:0] exp_q[$];
    logic [31:0] got_q[$];
    event seen;
    int err_total = 0;
    int num_checks = 0;

    initial begin
        forever #5 REF_CLK = ~REF_CLK;
    end

    key_irq_sleep_ctrl dut_u (.REF_CLK(REF_CLK), .RESETN(RESETN),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .KEY_IN(KEY_IN), .IRQ_ACK(IRQ_ACK), .NMI_REQ(NMI_REQ), .IRQ(IRQ),
        .NMI_OUT(NMI_OUT), .FAST_OSC_EN(FAST_OSC_EN),
        .SLOW_OSC_RUN(SLOW_OSC_RUN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
        .TIMER_EXT_CLK(TIMER_EXT_CLK));

    cpu_core_model cpu_u (.clk(REF_CLK), .rst_n(RESETN), .irq(IRQ),
        .ack_en(ack_en), .ack_delay(ack_delay), .irq_ack(IRQ_ACK));

    // oldest note against each observed result
    // drains every note, several may arrive in one time step
    always @(seen) begin
        logic [31:0] e;
        logic [31:0] g;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            num_checks++;
            if (e !== g) begin
                err_total++;
                $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
            end
        end
    end

    task print_verdict;
        // let the watcher drain the last notes first
        @(posedge REF_CLK);
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
        ->seen;
    endtask : check

    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (n >= 50) begin
            check(32'h0000_0001, 32'(HREADYOUT));
            print_verdict();
        end
    endtask : rdy

    task ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge REF_CLK);
        HSEL <= 1'b1;
        HADDR <= {14'h0000, idx, 2'b00};
        HTRANS <= 2'b10;
        HWRITE <= wr;
        rdy();
        HTRANS <= 2'b00;
        HWDATA <= wd;
        rdy();
        rd = HRDATA;
    endtask : ahb

    task wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, idx, d, x);
    endtask : wr

    task rd_chk(input logic [15:0] idx, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, idx, 32'h0000_0000, x);
        check(e, x);
        check(32'h0000_0000, 32'(HRESP));
    endtask : rd_chk

    function automatic logic pick(input int s);
        case (s)
            0: pick = IRQ;
            1: pick = NMI_OUT;
            2: pick = PERIPH_CLK_EN;
            default: pick = TIMER_EXT_CLK;
        endcase
    endfunction : pick

    // stay: hold for 20 cycles; else wait up to 20 for the level
    task out_is(input int s, input logic v, input bit stay);
        int n;
        logic bad;
        n = 0;
        bad = 1'b0;
        while (n < 20 && (stay || pick(s) !== v)) begin
            @(posedge REF_CLK);
            // a hold must keep the level at every edge, not only the last
            if (stay && pick(s) !== v) begin
                bad = 1'b1;
            end
            n++;
        end
        check(32'(v), 32'(bad ? !v : pick(s)));
        if (!stay && pick(s) !== v) begin
            print_verdict();
        end
    endtask : out_is

    task press(input int i);
        @(posedge REF_CLK);
        KEY_IN[i] <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        KEY_IN[i] <= 1'b1;
        repeat (8) @(posedge REF_CLK);
    endtask : press

    initial begin
        logic [31:0] v;
        void'($urandom(32'hf9d0e095));
        repeat (8) @(posedge REF_CLK);
        RESETN <= 1'b1;
        rd_chk(`IDX_FLAG, 32'h0000_0000);
        rd_chk(`IDX_STATUS, 32'h0000_00f0);
        rd_chk(16'h0100, 32'h0000_0000);
        repeat (3) begin
            v = 32'($urandom() & 4'hf);
            wr(`IDX_SELECT, v);
            rd_chk(`IDX_SELECT, v);
            wr(`IDX_MASK, ~v);
            rd_chk(`IDX_MASK, v ^ 32'h0000_000f);
        end
        wr(`IDX_SELECT, 32'h0000_0001);
        wr(`IDX_MASK, 32'h0000_0000);
        wr(`IDX_CTRL, 32'h0000_0001);
        press(0);
        rd_chk(`IDX_FLAG, 32'h0000_0001);
        out_is(0, 1'b0, 1);
        wr(`IDX_MASK, 32'h0000_0001);
        NMI_REQ <= 1'b1;
        out_is(0, 1'b0, 1);
        out_is(1, 1'b0, 1);
        wr(`IDX_WIDE_SP, 32'($urandom() & 10'h3ff));
        out_is(0, 1'b0, 1);
        wr(`IDX_NIB_SP, 32'($urandom() & 8'hff));
        out_is(0, 1'b1, 0);
        out_is(1, 1'b1, 0);
        wr(`IDX_WIDE_SP, 32'h0000_0100);
        out_is(0, 1'b0, 0);
        out_is(1, 1'b0, 0);
        wr(`IDX_NIB_SP, 32'h0000_0080);
        out_is(0, 1'b1, 0);
        NMI_REQ <= 1'b0;
        ack_en <= 1'b1;
        out_is(0, 1'b0, 0);
        rd_chk(`IDX_FLAG, 32'h0000_0001);
        ack_delay <= 4'hc;
        wr(`IDX_CTRL, 32'h0000_0001);
        out_is(0, 1'b1, 0);
        out_is(0, 1'b0, 0);
        wr(`IDX_CMD, 32'h0000_0002);
        out_is(0, 1'b1, 0);
        out_is(0, 1'b0, 0);
        wr(`IDX_FLAG, 32'h0000_0001);
        rd_chk(`IDX_FLAG, 32'h0000_0000);
        wr(`IDX_CTRL, 32'h0000_0001);
        out_is(0, 1'b0, 1);
        for (int i = 0; i < 4; i++) begin
            wr(`IDX_SELECT, 32'h0000_0001 << i);
            press(i);
            press((i + 1) % 4);
            rd_chk(`IDX_FLAG, 32'h0000_0001 << i);
            wr(`IDX_FLAG, 32'h0000_0001 << i);
        end
        wr(`IDX_SELECT, 32'h0000_000f);
        press(0);
        press(2);
        wr(`IDX_FLAG, 32'h0000_0001);
        rd_chk(`IDX_FLAG, 32'h0000_0004);
        KEY_IN[3] <= 1'b0;
        out_is(3, 1'b0, 0);
        KEY_IN[3] <= 1'b1;
        out_is(3, 1'b1, 0);
        rd_chk(`IDX_FLAG, 32'h0000_000c);
        wr(`IDX_FLAG, 32'h0000_000f);
        wr(`IDX_FILTER, 32'h0000_0000);
        wr(`IDX_SELECT, 32'h0000_0001);
        wr(`IDX_MASK, 32'h0000_0001);
        wr(`IDX_CTRL, 32'h0000_0001);
        wr(`IDX_CMD, 32'h0000_0001);
        out_is(2, 1'b0, 0);
        check(32'h0000_0000, 32'(FAST_OSC_EN));
        check(32'h0000_0001, 32'(SLOW_OSC_RUN));
        NMI_REQ <= 1'b1;
        press(1);
        out_is(2, 1'b0, 1);
        NMI_REQ <= 1'b0;
        press(0);
        out_is(2, 1'b1, 0);
        print_verdict();
    end
endmodule : key_irq_sleep_ctrl_tb
